// ---- rtl/cpr_map.svh ----
// Register offsets, field positions, reset values and fault causes of the core state block.
// Assumes a 32-bit classic Wishbone slave with byte addresses; every register is one aligned word.
`ifndef CPR_MAP_SVH
`define CPR_MAP_SVH
// ======================================================================
// Byte offsets (general registers 0..15 sit at four times their index)
`define CPR_OFS_GPR_LAST  8'h3c
`define CPR_OFS_ALL_ST    8'h40
`define CPR_OFS_APP_ST    8'h44
`define CPR_OFS_INT_ST    8'h48
`define CPR_OFS_EXE_ST    8'h4c
`define CPR_OFS_PRI_MASK  8'h50
`define CPR_OFS_FLT_MASK  8'h54
`define CPR_OFS_THR_MASK  8'h58
`define CPR_OFS_MODE_CTL  8'h5c
`define CPR_OFS_MAIN_SP   8'h60
`define CPR_OFS_PROC_SP   8'h64
`define CPR_OFS_STATE     8'h68
`define CPR_OFS_FCAUSE    8'h6c
// ======================================================================
// Field layout
`define CPR_APP_FIELD     32'hf800_0000
`define CPR_INT_FIELD     32'h0000_01ff
`define CPR_EXE_FIELD     32'h0600_fc00
`define CPR_EXE_CSTATE    24
`define CPR_CTL_UNPRIV    0
`define CPR_CTL_STKSEL    1
`define CPR_SP_ALIGN      32'hffff_fffc
`define CPR_PC_ALIGN      32'hffff_fffe
`define CPR_APP_LSB       27
`define CPR_HIGH_FIRST    4'h8
`define CPR_HIGH_LAST     4'hc
`define CPR_IDX_SP        4'hd
`define CPR_IDX_LINK      4'he
`define CPR_IDX_PC        4'hf
// ======================================================================
// Reset values
`define CPR_WORD_RST      32'h0000_0000
`define CPR_EXE_RST       32'h0100_0000
`define CPR_CTL_RST       2'h0
`define CPR_BIT_RST       1'h0
`define CPR_THR_RST       9'h000
`define CPR_INT_RST       9'h000
`define CPR_FC_RST        5'h00
// ======================================================================
// Fault cause bits
`define CPR_FC_USER_REG   0
`define CPR_FC_USER_INS   1
`define CPR_FC_HIGH_REG   2
`define CPR_FC_CSTATE     3
`define CPR_FC_LEGACY     4
`endif

// ---- rtl/cpr_pkg.sv ----
// Types shared by the core state block.
// Assumes nothing beyond a SystemVerilog compiler.
package cpr_pkg;
   // ======================================================================
   // Types
   typedef logic [31:0] cpr_word_t;
   typedef logic [8:0]  cpr_num_t;
   // Only three level-and-mode pairs exist; handler is always privileged
   typedef enum logic [1:0] {
      CPR_PRIV_THREAD  = 2'b00,
      CPR_PRIV_HANDLER = 2'b01,
      CPR_USER_THREAD  = 2'b10
   } cpr_mode_e;
   typedef enum logic [1:0] {
      CPR_IRQ_NORMAL    = 2'b00,
      CPR_IRQ_HARDFAULT = 2'b01,
      CPR_IRQ_NMI       = 2'b10
   } cpr_irq_kind_e;
endpackage : cpr_pkg

// ---- rtl/cpr_gpr_bank.sv ----
// General register bank, registers 0 to 12, one write port and two read ports.
// Assumes the caller never addresses index 13..15 here; those read back as zero.
`timescale 1ns/1ps
`default_nettype none
`include "cpr_map.svh"
module cpr_gpr_bank
   import cpr_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             we,
   input  wire logic [3:0]       widx,
   input  wire cpr_pkg::cpr_word_t wdata,
   input  wire logic [3:0]       ridx_a,
   input  wire logic [3:0]       ridx_b,
   output cpr_pkg::cpr_word_t    rdata_a,
   output cpr_pkg::cpr_word_t    rdata_b
);
   cpr_word_t bank_ff [0:12];
   cpr_word_t nxt_bank [0:12];

   always_comb begin
      for (int i = 0; i < 13; i++) begin
         nxt_bank[i] = (we && widx == 4'(i)) ? wdata : bank_ff[i];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 13; i++) bank_ff[i] <= `CPR_WORD_RST;
      end else begin
         for (int i = 0; i < 13; i++) bank_ff[i] <= nxt_bank[i];
      end
   end

   assign rdata_a = (ridx_a <= `CPR_HIGH_LAST) ? bank_ff[ridx_a] : `CPR_WORD_RST;
   assign rdata_b = (ridx_b <= `CPR_HIGH_LAST) ? bank_ff[ridx_b] : `CPR_WORD_RST;
endmodule : cpr_gpr_bank
`default_nettype wire

// ---- rtl/cpr_exc_mask.sv ----
// Exception masking decision from the three mask registers.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module cpr_exc_mask
   import cpr_pkg::*;
(
   input  wire logic                  pri_mask,
   input  wire logic                  flt_mask,
   input  wire logic [8:0]            thr_mask,
   input  wire cpr_pkg::cpr_irq_kind_e kind,
   input  wire logic [8:0]            prio,
   output logic                       allowed
);
   logic thr_block;

   always_comb begin
      // Same or higher priority value is held back; zero switches it off
      thr_block = (thr_mask != 9'h000) && (prio >= thr_mask);
      case (kind)
         CPR_IRQ_NMI:       allowed = 1'b1;
         CPR_IRQ_HARDFAULT: allowed = !flt_mask;
         CPR_IRQ_NORMAL:    allowed = !flt_mask && !pri_mask && !thr_block;
         default:           allowed = 1'b0;
      endcase
   end
endmodule : cpr_exc_mask
`default_nettype wire

// ---- rtl/cpr_top.sv ----
// Core architectural state: register bank, stacks, status words, masks, mode control.
// Assumes an instruction unit and exception controller on clk; software on classic Wishbone.
//
// What this block does
// - Handler mode exists only at privileged level
// - User level restricted access blocked and faults
// - Handler while servicing exception, otherwise thread
// - Registers 8-12 unreachable by 16-bit instructions
// - Stack pointer low two bits forced zero
// - Subroutine call writes return address to link
// - Program counter bit zero forced zero
// - Application flags live in bits 27-31
// - Current exception number in bits 0-8
// - Execution state bits 10-15 and 25-26
// - Bit 24 reads one; clearing it faults
// - Status parts readable combined or separately
// - Primary mask leaves only NMI and hard fault
// - Fault mask leaves only NMI
// - Threshold masks equal-or-higher values; zero disables
// - Control bit 0 selects thread privilege
// - Control bit 1 selects stack; zero in handler
// - Only compact encoding executes; legacy faults
`timescale 1ns/1ps
`default_nettype none
`include "cpr_map.svh"
module cpr_top
   import cpr_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [7:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire cpr_pkg::cpr_word_t     wb_dat_i,
   output cpr_pkg::cpr_word_t          wb_dat_o,
   output logic                        wb_ack_o,
   input  wire logic                   ins_valid,
   input  wire logic                   ins_wide,
   input  wire logic                   ins_legacy,
   input  wire logic                   ins_restricted,
   input  wire logic                   ins_we,
   input  wire logic [3:0]             ins_rd,
   input  wire logic [3:0]             ins_rs,
   input  wire cpr_pkg::cpr_word_t     ins_wdata,
   output cpr_pkg::cpr_word_t          rs_data_o,
   input  wire logic                   call_valid,
   input  wire cpr_pkg::cpr_word_t     call_ret_addr,
   input  wire logic                   pc_we,
   input  wire cpr_pkg::cpr_word_t     pc_next,
   output cpr_pkg::cpr_word_t          pc_o,
   input  wire logic                   flags_we,
   input  wire logic [4:0]             flags_in,
   input  wire logic                   exc_entry,
   input  wire cpr_pkg::cpr_num_t      exc_num,
   input  wire logic                   exc_return,
   input  wire cpr_pkg::cpr_num_t      exc_ret_num,
   input  wire logic                   irq_valid,
   input  wire cpr_pkg::cpr_irq_kind_e irq_kind,
   input  wire logic [8:0]             irq_prio,
   output logic                        irq_take_o,
   output logic                        fault_o,
   output logic                        handler_o,
   output logic                        user_o,
   output logic                        proc_stack_o
);
   // ======================================================================
   // State
   cpr_mode_e mode_ff, nxt_mode;
   cpr_word_t main_sp_ff, nxt_main_sp, proc_sp_ff, nxt_proc_sp;
   cpr_word_t link_ff, nxt_link, pc_ff, nxt_pc;
   cpr_word_t app_ff, nxt_app, exe_ff, nxt_exe;
   cpr_num_t  int_ff, nxt_int;
   logic      pri_ff, nxt_pri, flt_ff, nxt_flt;
   logic [8:0] thr_ff, nxt_thr;
   logic [1:0] ctl_ff, nxt_ctl;
   logic      saved_sel_ff, nxt_saved_sel;
   logic [4:0] fcause_ff, nxt_fcause;
   logic      ack_ff, nxt_ack, fault_ff, nxt_fault, take_ff, nxt_take;
   cpr_word_t rdat_ff, nxt_rdat, rs_ff, nxt_rs;

   // ======================================================================
   // Helpers
   logic      wb_go, wb_wr, in_handler, is_user, sel_proc, allowed;
   logic      blk_user, ins_ok, hi_fault, leg_fault, rst_fault, cst_fault;
   logic      g_we;
   logic [3:0] g_widx;
   cpr_word_t g_wdata, g_rd_wb, g_rd_ins, old_val, wr_val, act_sp, all_st;
   logic [4:0] fc_set;
   logic [1:0] ctl_wr;

   function automatic cpr_word_t merge(input cpr_word_t old, input cpr_word_t nw, input logic [3:0] sel);
      cpr_word_t r;
      for (int b = 0; b < 4; b++) begin
         r[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
      return r;
   endfunction : merge

   cpr_gpr_bank u_bank (
      .clk    (clk),
      .arst_n (arst_n),
      .we     (g_we),
      .widx   (g_widx),
      .wdata  (g_wdata),
      .ridx_a (wb_adr_i[5:2]),
      .ridx_b (ins_rs),
      .rdata_a(g_rd_wb),
      .rdata_b(g_rd_ins)
   );

   cpr_exc_mask u_mask (
      .pri_mask(pri_ff),
      .flt_mask(flt_ff),
      .thr_mask(thr_ff),
      .kind    (irq_kind),
      .prio    (irq_prio),
      .allowed (allowed)
   );

   // ======================================================================
   // Mode decode
   always_comb begin
      in_handler = (mode_ff == CPR_PRIV_HANDLER);
      is_user    = (mode_ff == CPR_USER_THREAD);
      sel_proc   = !in_handler && ctl_ff[`CPR_CTL_STKSEL];
      act_sp     = sel_proc ? proc_sp_ff : main_sp_ff;
      all_st     = (app_ff & `CPR_APP_FIELD) | {23'h0, int_ff} | (exe_ff & `CPR_EXE_FIELD)
                   | (32'h1 << `CPR_EXE_CSTATE);
   end

   // ======================================================================
   // Register read mux and access checks
   always_comb begin
      // An instruction owns the write ports; a bus cycle waits for a free slot
      wb_go    = wb_cyc_i && wb_stb_i && !ack_ff && !ins_valid;
      // User software reaches only the general registers and the flags
      blk_user = is_user && (wb_adr_i > `CPR_OFS_GPR_LAST) && (wb_adr_i[7:2] != `CPR_OFS_APP_ST >> 2);
      wb_wr    = wb_go && wb_we_i && !blk_user;
      case (wb_adr_i[7:2])
         `CPR_OFS_ALL_ST >> 2:   old_val = all_st;
         `CPR_OFS_APP_ST >> 2:   old_val = app_ff & `CPR_APP_FIELD;
         `CPR_OFS_INT_ST >> 2:   old_val = {23'h0, int_ff};
         `CPR_OFS_EXE_ST >> 2:   old_val = (exe_ff & `CPR_EXE_FIELD) | (32'h1 << `CPR_EXE_CSTATE);
         `CPR_OFS_PRI_MASK >> 2: old_val = {31'h0, pri_ff};
         `CPR_OFS_FLT_MASK >> 2: old_val = {31'h0, flt_ff};
         `CPR_OFS_THR_MASK >> 2: old_val = {23'h0, thr_ff};
         `CPR_OFS_MODE_CTL >> 2: old_val = {30'h0, ctl_ff};
         `CPR_OFS_MAIN_SP >> 2:  old_val = main_sp_ff;
         `CPR_OFS_PROC_SP >> 2:  old_val = proc_sp_ff;
         `CPR_OFS_STATE >> 2:    old_val = {29'h0, sel_proc, is_user, in_handler};
         `CPR_OFS_FCAUSE >> 2:   old_val = {27'h0, fcause_ff};
         default: begin
            if (wb_adr_i <= `CPR_OFS_GPR_LAST) begin
               case (wb_adr_i[5:2])
                  `CPR_IDX_SP:   old_val = act_sp;
                  `CPR_IDX_LINK: old_val = link_ff;
                  `CPR_IDX_PC:   old_val = pc_ff;
                  default:       old_val = g_rd_wb;
               endcase
            end else begin
               old_val = `CPR_WORD_RST;
            end
         end
      endcase
      wr_val = merge(old_val, wb_dat_i, wb_sel_i);
      // Instruction checks
      leg_fault = ins_valid && ins_legacy;
      rst_fault = ins_valid && ins_restricted && is_user;
      hi_fault  = ins_valid && !ins_wide && ((ins_we && ins_rd >= `CPR_HIGH_FIRST && ins_rd <= `CPR_HIGH_LAST)
                  || (ins_rs >= `CPR_HIGH_FIRST && ins_rs <= `CPR_HIGH_LAST));
      ins_ok    = ins_valid && ins_we && !leg_fault && !rst_fault && !hi_fault;
      cst_fault = wb_wr && !wr_val[`CPR_EXE_CSTATE]
                  && (wb_adr_i[7:2] == `CPR_OFS_ALL_ST >> 2 || wb_adr_i[7:2] == `CPR_OFS_EXE_ST >> 2);
      fc_set = '0;
      fc_set[`CPR_FC_USER_REG] = wb_go && blk_user;
      fc_set[`CPR_FC_USER_INS] = rst_fault;
      fc_set[`CPR_FC_HIGH_REG] = hi_fault;
      fc_set[`CPR_FC_CSTATE]   = cst_fault;
      fc_set[`CPR_FC_LEGACY]   = leg_fault;
      // Single write port into the general bank
      g_we    = (ins_ok && ins_rd <= `CPR_HIGH_LAST) || (wb_wr && wb_adr_i <= `CPR_OFS_GPR_LAST
                && wb_adr_i[5:2] <= `CPR_HIGH_LAST);
      g_widx  = ins_ok ? ins_rd : wb_adr_i[5:2];
      g_wdata = ins_ok ? ins_wdata : wr_val;
   end

   // ======================================================================
   // Next state
   always_comb begin
      nxt_main_sp   = main_sp_ff;
      nxt_proc_sp   = proc_sp_ff;
      nxt_link      = link_ff;
      nxt_pc        = pc_ff;
      nxt_app       = app_ff;
      nxt_exe       = exe_ff;
      nxt_int       = int_ff;
      nxt_pri       = pri_ff;
      nxt_flt       = flt_ff;
      nxt_thr       = thr_ff;
      nxt_ctl       = ctl_ff;
      nxt_saved_sel = saved_sel_ff;
      nxt_mode      = mode_ff;
      ctl_wr        = ctl_ff;
      // Instruction writes to 13..15
      if (ins_ok && ins_rd == `CPR_IDX_SP) begin
         if (sel_proc) nxt_proc_sp = ins_wdata & `CPR_SP_ALIGN;
         else nxt_main_sp = ins_wdata & `CPR_SP_ALIGN;
      end
      if (ins_ok && ins_rd == `CPR_IDX_LINK) nxt_link = ins_wdata;
      if (ins_ok && ins_rd == `CPR_IDX_PC) nxt_pc = ins_wdata & `CPR_PC_ALIGN;
      // Bus writes
      if (wb_wr) begin
         case (wb_adr_i[7:2])
            `CPR_OFS_ALL_ST >> 2: begin
               nxt_app = wr_val & `CPR_APP_FIELD;
               nxt_exe = (wr_val & `CPR_EXE_FIELD) | (32'h1 << `CPR_EXE_CSTATE);
            end
            `CPR_OFS_APP_ST >> 2:   nxt_app = wr_val & `CPR_APP_FIELD;
            `CPR_OFS_EXE_ST >> 2:   nxt_exe = (wr_val & `CPR_EXE_FIELD) | (32'h1 << `CPR_EXE_CSTATE);
            `CPR_OFS_PRI_MASK >> 2: nxt_pri = wr_val[0];
            `CPR_OFS_FLT_MASK >> 2: nxt_flt = wr_val[0];
            `CPR_OFS_THR_MASK >> 2: nxt_thr = wr_val[8:0];
            `CPR_OFS_MODE_CTL >> 2: begin
               ctl_wr = wr_val[1:0];
               if (in_handler) ctl_wr[`CPR_CTL_STKSEL] = 1'b0;
            end
            `CPR_OFS_MAIN_SP >> 2:  nxt_main_sp = wr_val & `CPR_SP_ALIGN;
            `CPR_OFS_PROC_SP >> 2:  nxt_proc_sp = wr_val & `CPR_SP_ALIGN;
            default: begin
               if (wb_adr_i <= `CPR_OFS_GPR_LAST) begin
                  case (wb_adr_i[5:2])
                     `CPR_IDX_SP: begin
                        if (sel_proc) nxt_proc_sp = wr_val & `CPR_SP_ALIGN;
                        else nxt_main_sp = wr_val & `CPR_SP_ALIGN;
                     end
                     `CPR_IDX_LINK: nxt_link = wr_val;
                     `CPR_IDX_PC:   nxt_pc = wr_val & `CPR_PC_ALIGN;
                     default: ;
                  endcase
               end
            end
         endcase
      end
      // Core-side updates take priority over the same register from other paths
      if (flags_we) nxt_app = {flags_in, 27'h0};
      if (call_valid) nxt_link = call_ret_addr;
      if (pc_we) nxt_pc = pc_next & `CPR_PC_ALIGN;
      nxt_ctl = ctl_wr;
      // Mode transitions; handler never carries the user level
      if (exc_entry) begin
         nxt_mode = CPR_PRIV_HANDLER;
         nxt_int  = exc_num;
         if (!in_handler) nxt_saved_sel = ctl_wr[`CPR_CTL_STKSEL];
         nxt_ctl[`CPR_CTL_STKSEL] = 1'b0;
      end else if (exc_return && in_handler) begin
         nxt_int = exc_ret_num;
         if (exc_ret_num == 9'h000) begin
            // Stack choice made before entry comes back with thread mode
            nxt_ctl[`CPR_CTL_STKSEL] = saved_sel_ff;
            nxt_mode = ctl_wr[`CPR_CTL_UNPRIV] ? CPR_USER_THREAD : CPR_PRIV_THREAD;
         end
      end else if (!in_handler) begin
         nxt_mode = ctl_wr[`CPR_CTL_UNPRIV] ? CPR_USER_THREAD : CPR_PRIV_THREAD;
      end
   end

   // ======================================================================
   // Bus answer, fault and interrupt decision
   always_comb begin
      nxt_ack    = wb_go;
      nxt_rdat   = (wb_go && !wb_we_i && !blk_user) ? old_val : `CPR_WORD_RST;
      nxt_rs     = (ins_rs == `CPR_IDX_SP) ? act_sp :
                   (ins_rs == `CPR_IDX_LINK) ? link_ff :
                   (ins_rs == `CPR_IDX_PC) ? pc_ff : g_rd_ins;
      nxt_fault  = |fc_set;
      // Hardware set wins over a write-one clear in the same cycle
      nxt_fcause = fcause_ff;
      if (wb_wr && wb_adr_i[7:2] == `CPR_OFS_FCAUSE >> 2) nxt_fcause = fcause_ff & ~wr_val[4:0];
      nxt_fcause = nxt_fcause | fc_set;
      nxt_take   = irq_valid && allowed;
   end

   // ======================================================================
   // Registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_ff      <= CPR_PRIV_THREAD;
         main_sp_ff   <= `CPR_WORD_RST;
         proc_sp_ff   <= `CPR_WORD_RST;
         link_ff      <= `CPR_WORD_RST;
         pc_ff        <= `CPR_WORD_RST;
         app_ff       <= `CPR_WORD_RST;
         exe_ff       <= `CPR_EXE_RST;
         int_ff       <= `CPR_INT_RST;
         pri_ff       <= `CPR_BIT_RST;
         flt_ff       <= `CPR_BIT_RST;
         thr_ff       <= `CPR_THR_RST;
         ctl_ff       <= `CPR_CTL_RST;
         saved_sel_ff <= `CPR_BIT_RST;
         fcause_ff    <= `CPR_FC_RST;
         ack_ff       <= 1'b0;
         fault_ff     <= 1'b0;
         take_ff      <= 1'b0;
         rdat_ff      <= `CPR_WORD_RST;
         rs_ff        <= `CPR_WORD_RST;
      end else begin
         mode_ff      <= nxt_mode;
         main_sp_ff   <= nxt_main_sp;
         proc_sp_ff   <= nxt_proc_sp;
         link_ff      <= nxt_link;
         pc_ff        <= nxt_pc;
         app_ff       <= nxt_app;
         exe_ff       <= nxt_exe;
         int_ff       <= nxt_int;
         pri_ff       <= nxt_pri;
         flt_ff       <= nxt_flt;
         thr_ff       <= nxt_thr;
         ctl_ff       <= nxt_ctl;
         saved_sel_ff <= nxt_saved_sel;
         fcause_ff    <= nxt_fcause;
         ack_ff       <= nxt_ack;
         fault_ff     <= nxt_fault;
         take_ff      <= nxt_take;
         rdat_ff      <= nxt_rdat;
         rs_ff        <= nxt_rs;
      end
   end

   // ======================================================================
   // Outputs: mode flags are registered from the next mode state
   logic hnd_ff, usr_ff, psel_ff;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hnd_ff  <= 1'b0;
         usr_ff  <= 1'b0;
         psel_ff <= 1'b0;
      end else begin
         hnd_ff  <= (nxt_mode == CPR_PRIV_HANDLER);
         usr_ff  <= (nxt_mode == CPR_USER_THREAD);
         psel_ff <= (nxt_mode != CPR_PRIV_HANDLER) && nxt_ctl[`CPR_CTL_STKSEL];
      end
   end

   assign wb_ack_o     = ack_ff;
   assign wb_dat_o     = rdat_ff;
   assign rs_data_o    = rs_ff;
   assign pc_o         = pc_ff;
   assign fault_o      = fault_ff;
   assign irq_take_o   = take_ff;
   assign handler_o    = hnd_ff;
   assign user_o       = usr_ff;
   assign proc_stack_o = psel_ff;
endmodule : cpr_top
`default_nettype wire

// ---- tb/cpr_top_props.sv ----
// Port assertions for the core state block.
// Assumes binding into cpr_top; one clock, asynchronous reset arst_n.
`timescale 1ns/1ps
`default_nettype none
module cpr_top_props
   import cpr_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   arst_n,
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_ack_o,
   input wire logic                   ins_valid,
   input wire logic                   ins_wide,
   input wire logic                   ins_legacy,
   input wire logic                   ins_restricted,
   input wire logic [3:0]             ins_rs,
   input wire logic                   exc_entry,
   input wire logic                   irq_valid,
   input wire cpr_pkg::cpr_irq_kind_e irq_kind,
   input wire logic                   irq_take_o,
   input wire logic                   fault_o,
   input wire logic                   handler_o,
   input wire logic                   user_o,
   input wire logic                   proc_stack_o,
   input wire cpr_pkg::cpr_word_t     pc_o
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ==========
   // Bus handshake
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !ins_valid;
   endsequence
   sequence s_ack;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   chk_bus_answer: assert property (s_take |=> s_ack)
      else $error("bus answer is not a single pulse");
   // ==========
   // Mode, stack and faults
   chk_handler_priv: assert property (handler_o |-> !user_o)
      else $error("user level seen in handler mode");
   chk_entry_mode: assert property (exc_entry |=> handler_o)
      else $error("entry did not reach handler");
   chk_handler_stack: assert property (handler_o |-> !proc_stack_o)
      else $error("process stack active in handler mode");
   chk_pc_align: assert property (pc_o[0] == 1'b0)
      else $error("program counter bit 0 set");
   chk_user_block: assert property (ins_valid && ins_restricted && user_o |=> fault_o)
      else $error("user restricted op did not fault");
   chk_high_narrow: assert property (ins_valid && !ins_wide && ins_rs inside {[8:12]} |=> fault_o)
      else $error("narrow instruction reached a high register");
   chk_legacy_fault: assert property (ins_valid && ins_legacy |=> fault_o)
      else $error("legacy encoding did not fault");
   chk_nmi_taken: assert property (irq_valid && irq_kind == CPR_IRQ_NMI |=> irq_take_o)
      else $error("nonmaskable request not taken");
   chk_reset_mode: assert property ($rose(arst_n) |-> !handler_o && !user_o && !proc_stack_o)
      else $error("mode flags not clear after reset");
endmodule : cpr_top_props
bind cpr_top cpr_top_props chk (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the core state block.
// Assumes cpr_top with its Wishbone offsets; no other block around it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cpr_pkg::*;
   logic clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ins_valid, ins_wide, ins_legacy, ins_restricted;
   logic ins_we, call_valid, pc_we, flags_we, exc_entry, exc_return, irq_valid, irq_take_o, fault_o;
   logic handler_o, user_o, proc_stack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, ins_rd, ins_rs;
   logic [4:0] flags_in;
   logic [8:0] irq_prio, th, p;
   cpr_word_t wb_dat_i, wb_dat_o, ins_wdata, rs_data_o, call_ret_addr, pc_next, pc_o, q, r, g[13];
   cpr_num_t exc_num, exc_ret_num;
   cpr_irq_kind_e irq_kind;
   int checks = 0, mismatches = 0, cycles = 0, nf = 0, n0;
   cpr_top uut (.*);
   always #25 clk = ~clk;
   // ==========
   // Helpers
   function automatic cpr_word_t lfsr(cpr_word_t s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic take(logic pm, fm, logic [8:0] t, v, logic [1:0] k);
      if (k == 2'h2) return 1'b1;
      if (fm) return 1'b0;
      if (k == 2'h1) return 1'b1;
      return !pm && (t == 9'h000 || v < t);
   endfunction : take
   task automatic chk(input cpr_word_t got, exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // Holds the request until ack is seen high; the bench timeout ends a hang
   task automatic wb(input logic we, input logic [7:0] a, input cpr_word_t d, output cpr_word_t o);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
         @(posedge clk);
      while (wb_ack_o !== 1'b1);
      o = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      tick(1);
   endtask : wb
   task automatic rd(input logic [7:0] a, input cpr_word_t e);
      cpr_word_t v;
      wb(1'b0, a, 32'h0, v);
      chk(v, e);
   endtask : rd
   task automatic ins(input logic w, lg, rs, input logic [3:0] s);
      ins_valid <= 1'b1;
      ins_wide <= w;
      ins_legacy <= lg;
      ins_restricted <= rs;
      ins_rs <= s;
      tick(1);
      ins_valid <= 1'b0;
      tick(2);
   endtask : ins
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   // Fault pulses are counted so none slips between checks
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (fault_o === 1'b1) nf <= nf + 1;
      if (cycles == 5000) begin
         mismatches++;
         print_verdict();
      end
   end
   // ==========
   // Scenarios
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, ins_valid, ins_wide, ins_legacy, ins_restricted, ins_we} = 8'h01;
      {call_valid, pc_we, flags_we, exc_entry, exc_return, irq_valid} = 6'h00;
      {wb_adr_i, ins_rd, ins_rs, flags_in, irq_prio, exc_num, exc_ret_num} = 48'h0;
      {wb_dat_i, ins_wdata, call_ret_addr, pc_next} = 128'h0;
      wb_sel_i = 4'hf;
      irq_kind = CPR_IRQ_NORMAL;
      r = 32'h0000_005c;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      tick(1);
      chk({29'h0, handler_o, user_o, proc_stack_o}, 32'h0);
      rd(8'h5c, 32'h0);
      rd(8'h50, 32'h0);
      rd(8'h4c, 32'h0100_0000);
      $display("reset test done");
      for (int i = 0; i < 13; i++) begin
         r = lfsr(r);
         g[i] = r;
         wb(1'b1, 8'(i * 4), r, q);
      end
      for (int i = 0; i < 13; i++) rd(8'(i * 4), g[i]);
      wb_sel_i <= 4'h1;
      wb(1'b1, 8'h00, 32'hffff_ffff, q);
      wb_sel_i <= 4'hf;
      rd(8'h00, {g[0][31:8], 8'hff});
      for (int i = 0; i < 4; i++) begin
         n0 = nf;
         ins(i != 0, i == 2, i == 3, 4'(9 - i));
         chk(nf - n0, i % 2 == 0);
         if (i % 2) chk(rs_data_o, g[9 - i]);
      end
      $display("register test done");
      r = lfsr(r);
      call_valid <= 1'b1;
      call_ret_addr <= r;
      pc_we <= 1'b1;
      pc_next <= r | 32'h1;
      flags_we <= 1'b1;
      flags_in <= r[20:16];
      tick(1);
      {call_valid, pc_we, flags_we, ins_wdata} <= {3'h0, ~r};
      ins(1'b1, 1'b0, 1'b0, 4'he);
      chk(rs_data_o, r);
      chk(pc_o, r & 32'hffff_fffe);
      rd(8'h00, ~r);
      rd(8'h44, {r[20:16], 27'h0});
      n0 = nf;
      wb(1'b1, 8'h4c, 32'h0, q);
      rd(8'h40, {r[20:16], 27'h0} | 32'h0100_0000);
      chk(nf - n0, 1);
      $display("status test done");
      for (int i = 0; i < 24; i++) begin
         r = lfsr(r);
         th = r[3] ? r[12:4] : 9'h000;
         p = r[2] ? th : r[24:16];
         wb(1'b1, 8'h50, {31'h0, r[0]}, q);
         wb(1'b1, 8'h54, {31'h0, r[1]}, q);
         wb(1'b1, 8'h58, {23'h0, th}, q);
         irq_kind <= cpr_irq_kind_e'(r[14:13] % 2'h3);
         irq_prio <= p;
         irq_valid <= 1'b1;
         tick(1);
         irq_valid <= 1'b0;
         tick(1);
         chk(irq_take_o, take(r[0], r[1], th, p, r[14:13] % 2'h3));
      end
      $display("mask test done");
      wb(1'b1, 8'h5c, 32'h2, q);
      chk(proc_stack_o, 1);
      r = lfsr(r);
      exc_num <= r[8:0];
      exc_entry <= 1'b1;
      tick(1);
      exc_entry <= 1'b0;
      tick(2);
      chk({handler_o, proc_stack_o}, 2'b10);
      rd(8'h48, r[8:0]);
      exc_return <= 1'b1;
      tick(1);
      exc_return <= 1'b0;
      tick(2);
      chk({handler_o, proc_stack_o}, 2'b01);
      wb(1'b1, 8'h64, r, q);
      rd(8'h34, r & 32'hffff_fffc);
      wb(1'b1, 8'h5c, 32'h3, q);
      chk(user_o, 1);
      n0 = nf;
      rd(8'h50, 32'h0);
      ins(1'b1, 1'b0, 1'b1, 4'h0);
      chk(nf - n0, 2);
      $display("mode test done");
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
